// [core/qa_watchdog_pkg.sv]
// How it works
// - Pending question held, readable without side effect
// - Question event only on fault-free read
// - Multi mode response is four answer bytes
// - Countdown loads 0x3, decrements per answer
// - Single mode: one byte, countdown stays 0x1
// - Restart on time-out, config change, final byte
// - First window (setting+1) steps, diag-only change
// - Second window (setting+1) steps of 0.55 ms
// - Single mode: closed window first, (setting+1) steps
// - Open window (setting+1) steps of 0.55 ms
// - Timebase step of 0.55 ms from clock
// - Lock command blocks window setting writes
// - New question in question field two cycles after final byte (chain one cycle after)
// - Four-bit chain, state zero stepped as if one
// - Multi valid: four correct, ordered, timed
// - Single valid: none closed, one correct open
// - Status flags set only at cycle end
// - Status read returns previous flags, clears them
// - Init loads countdown 0x3 multi, 0x1 single
// - Init clears flags, fail flag, question engine
// - Mode bit 0 multi, 1 single
// - Fail counter +1 wrong, -1 correct, saturating
// - No answer counts time-out, fail counter +1
// - Power-on reset sets fail counter 0x5
package qa_watchdog_pkg;

    // Timebase
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_NS = 550000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int STEP_CNT_W = 16;

    // Answer countdown loads
    localparam logic [1:0] COUNT_LOAD_MULTI = 2'h3;
    localparam logic [1:0] COUNT_LOAD_SINGLE = 2'h1;
    localparam logic [1:0] COUNT_FINAL = 2'h0;

    // Failure counter
    localparam logic [3:0] FAIL_CNT_RESET = 4'h5;
    localparam logic [3:0] FAIL_CNT_MAX = 4'hF;
    localparam logic [3:0] FAIL_CNT_MIN = 4'h0;

    // Question chain
    localparam logic [3:0] QUESTION_SEED = 4'h1;
    localparam logic [3:0] QUESTION_ZERO = 4'h0;

    // Window settings after reset
    localparam logic [7:0] WIN1_RESET = 8'h0F;
    localparam logic [4:0] WIN2_RESET = 5'h0F;
    localparam logic [1:0] FEEDBACK_RESET = 2'h0;

    // Mode bit values
    localparam logic MODE_MULTI = 1'b0;
    localparam logic MODE_SINGLE = 1'b1;

    typedef enum logic {
        PH_FIRST = 1'b0,
        PH_SECOND = 1'b1
    } phase_t;

endpackage

// [core/question_chain.sv]
// Four-bit question state chain
module question_chain (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic init, // Reload seed
    input wire logic advance, // Step to next question
    output logic [3:0] question_q // Current question
);

    logic [3:0] seed;
    logic [3:0] question_d;

    // Zero state replaced before stepping
    always_comb begin
        seed = (question_q == qa_watchdog_pkg::QUESTION_ZERO) ? qa_watchdog_pkg::QUESTION_SEED : question_q;
        question_d = {seed[2:0], seed[3] ^ seed[2]};
    end

    // Chain register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            question_q <= qa_watchdog_pkg::QUESTION_SEED;
        end else if (init) begin
            question_q <= qa_watchdog_pkg::QUESTION_SEED;
        end else if (advance) begin
            question_q <= question_d;
        end
    end

endmodule // question_chain

// [core/question_answer_watchdog.sv]
// Question and answer watchdog
module question_answer_watchdog #(
    parameter int STEP_CYC = qa_watchdog_pkg::STEP_CYCLES // Clocks per window step
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic state_a, // State_a state, settings writable
    input wire logic answer_mode_select, // 0 multi, 1 single
    input wire logic cfg_wr, // Window settings write strobe
    input wire logic [7:0] window_one_config, // First or closed window setting
    input wire logic [4:0] window_two_config, // Second or open window setting
    input wire logic [1:0] answer_feedback_config, // Feedback select
    input wire logic config_write_lock_cmd, // Lock command strobe
    input wire logic init_req, // Initialization event strobe
    input wire logic question_rd, // Question read frame done
    input wire logic frame_fault, // Fault on that frame
    input wire logic answer_wr, // Answer write strobe
    input wire logic [7:0] answer_byte_field, // Answer byte
    input wire logic status_rd, // Status read strobe
    output logic [3:0] pending_question, // Current question
    output logic [1:0] answer_countdown, // Answer countdown
    output logic question_event, // Valid question read pulse
    output logic wrong_answer_flag, // Wrong answer status
    output logic early_answer_flag, // Early answer status
    output logic order_error_flag, // Order error status
    output logic timeout_flag, // Time-out status
    output logic watchdog_fail_flag, // Fail counter went up
    output logic [3:0] failure_counter, // Failure counter
    output logic second_window, // In second or open window
    output logic config_locked, // Window settings locked
    output logic [7:0] first_window_length, // First window setting
    output logic [4:0] second_window_length // Second window setting
);

    logic [qa_watchdog_pkg::STEP_CNT_W-1:0] step_cnt_q;
    logic step_tick;
    logic [7:0] win_cnt_q;
    logic [7:0] win_limit;
    logic win_done;
    qa_watchdog_pkg::phase_t phase_q;
    logic mode_q;
    logic [1:0] feedback_q;
    logic [1:0] cnt_q;
    logic any_answer_q;
    logic run_wrong_q;
    logic run_early_q;
    logic run_order_q;
    logic mode_upd;
    logic win_upd;
    logic cfg_change;
    logic new_mode;
    logic [7:0] expected;
    logic ans_ok;
    logic wr_wrong;
    logic wr_early;
    logic wr_order;
    logic wr_final;
    logic wr_count;
    logic timeout_end;
    logic run_end;
    logic run_err;
    logic restart;
    logic fail_up;
    logic fail_down;
    logic question_adv;
    logic [3:0] question;

    // Expected byte, fixed xor mapping
    function automatic logic [7:0] expect_byte(input logic [3:0] q, input logic [1:0] c, input logic [1:0] f);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = q ^ {c, f};
        lo = ~q ^ {f, c};
        return {hi, lo};
    endfunction

    // Settings update detection
    always_comb begin
        mode_upd = state_a && (answer_mode_select != mode_q);
        win_upd = cfg_wr && state_a && !config_locked;
        cfg_change = mode_upd || win_upd;
        new_mode = mode_upd ? answer_mode_select : mode_q;
    end

    // Step timebase
    always_comb begin
        step_tick = (step_cnt_q == qa_watchdog_pkg::STEP_CNT_W'(STEP_CYC - 1));
        win_limit = (phase_q == qa_watchdog_pkg::PH_FIRST) ? first_window_length : {3'h0, second_window_length};
        win_done = step_tick && (win_cnt_q == win_limit);
    end

    // Answer classification
    always_comb begin
        expected = expect_byte(question, cnt_q, feedback_q);
        ans_ok = (answer_byte_field == expected);
        wr_wrong = 1'b0;
        wr_early = 1'b0;
        wr_order = 1'b0;
        wr_final = 1'b0;
        wr_count = 1'b0;
        if (answer_wr) begin
            if (mode_q == qa_watchdog_pkg::MODE_SINGLE) begin
                if (phase_q == qa_watchdog_pkg::PH_FIRST) begin
                    wr_early = 1'b1;
                end else begin
                    wr_wrong = !ans_ok;
                    wr_final = 1'b1;
                end
            end else if (phase_q == qa_watchdog_pkg::PH_FIRST) begin
                if (cnt_q == qa_watchdog_pkg::COUNT_FINAL) begin
                    wr_early = 1'b1;
                    wr_order = 1'b1;
                end else begin
                    wr_wrong = !ans_ok;
                    wr_count = 1'b1;
                end
            end else if (cnt_q != qa_watchdog_pkg::COUNT_FINAL) begin
                wr_order = 1'b1;
                wr_wrong = !ans_ok;
                wr_count = 1'b1;
            end else begin
                wr_wrong = !ans_ok;
                wr_final = 1'b1;
            end
        end
    end

    // Cycle end and restart
    always_comb begin
        timeout_end = win_done && (phase_q == qa_watchdog_pkg::PH_SECOND) && !wr_final;
        run_end = (wr_final || timeout_end) && !cfg_change && !init_req;
        run_err = run_wrong_q || run_early_q || run_order_q || wr_wrong || wr_early || wr_order;
        restart = init_req || cfg_change || run_end;
        fail_up = (run_end && (run_err || timeout_end)) || (cfg_change && !init_req);
        fail_down = run_end && !run_err && !timeout_end;
        question_adv = run_end;
    end

    // Question engine
    question_chain u_chain (
        .clk(clk),
        .rst_n(rst_n),
        .init(init_req),
        .advance(question_adv),
        .question_q(question)
    );

    // Question field mirror
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_question <= qa_watchdog_pkg::QUESTION_SEED;
        end else begin
            pending_question <= question;
        end
    end

    // Question read event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            question_event <= 1'b0;
        end else begin
            question_event <= question_rd && !frame_fault;
        end
    end

    // Mode, settings and lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= qa_watchdog_pkg::MODE_MULTI;
            feedback_q <= qa_watchdog_pkg::FEEDBACK_RESET;
            first_window_length <= qa_watchdog_pkg::WIN1_RESET;
            second_window_length <= qa_watchdog_pkg::WIN2_RESET;
            config_locked <= 1'b0;
        end else begin
            if (state_a) begin
                mode_q <= answer_mode_select;
                feedback_q <= answer_feedback_config;
            end
            if (win_upd) begin
                first_window_length <= window_one_config;
                second_window_length <= window_two_config;
            end
            if (config_write_lock_cmd) begin
                config_locked <= 1'b1;
            end
        end
    end

    // Step counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_q <= '0;
        end else if (restart || step_tick) begin
            step_cnt_q <= '0;
        end else begin
            step_cnt_q <= step_cnt_q + 1'b1;
        end
    end

    // Window phase and step count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= qa_watchdog_pkg::PH_FIRST;
            win_cnt_q <= 8'h00;
        end else if (restart) begin
            phase_q <= qa_watchdog_pkg::PH_FIRST;
            win_cnt_q <= 8'h00;
        end else if (win_done) begin
            phase_q <= qa_watchdog_pkg::PH_SECOND;
            win_cnt_q <= 8'h00;
        end else if (step_tick) begin
            win_cnt_q <= win_cnt_q + 8'h01;
        end
    end

    // Window phase output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_window <= 1'b0;
        end else if (restart) begin
            second_window <= 1'b0;
        end else if (win_done) begin
            second_window <= 1'b1;
        end
    end

    // Answer countdown
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= qa_watchdog_pkg::COUNT_LOAD_MULTI;
        end else if (restart) begin
            cnt_q <= (new_mode == qa_watchdog_pkg::MODE_SINGLE) ? qa_watchdog_pkg::COUNT_LOAD_SINGLE
                                                                 : qa_watchdog_pkg::COUNT_LOAD_MULTI;
        end else if (wr_count) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    // Countdown output copy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            answer_countdown <= qa_watchdog_pkg::COUNT_LOAD_MULTI;
        end else if (restart) begin
            answer_countdown <= (new_mode == qa_watchdog_pkg::MODE_SINGLE) ? qa_watchdog_pkg::COUNT_LOAD_SINGLE
                                                                            : qa_watchdog_pkg::COUNT_LOAD_MULTI;
        end else if (wr_count) begin
            answer_countdown <= cnt_q - 2'h1;
        end
    end

    // Per-run error accumulation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_wrong_q <= 1'b0;
            run_early_q <= 1'b0;
            run_order_q <= 1'b0;
            any_answer_q <= 1'b0;
        end else if (restart) begin
            run_wrong_q <= 1'b0;
            run_early_q <= 1'b0;
            run_order_q <= 1'b0;
            any_answer_q <= 1'b0;
        end else if (answer_wr) begin
            run_wrong_q <= run_wrong_q || wr_wrong;
            run_early_q <= run_early_q || wr_early;
            run_order_q <= run_order_q || wr_order;
            any_answer_q <= 1'b1;
        end
    end

    // Status flags, set at cycle end wins over read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrong_answer_flag <= 1'b0;
            early_answer_flag <= 1'b0;
            order_error_flag <= 1'b0;
            timeout_flag <= 1'b0;
        end else if (init_req) begin
            wrong_answer_flag <= 1'b0;
            early_answer_flag <= 1'b0;
            order_error_flag <= 1'b0;
            timeout_flag <= 1'b0;
        end else begin
            wrong_answer_flag <= (wrong_answer_flag && !status_rd) ||
                                 (run_end && (run_wrong_q || wr_wrong));
            early_answer_flag <= (early_answer_flag && !status_rd) ||
                                 (run_end && (run_early_q || wr_early));
            order_error_flag <= (order_error_flag && !status_rd) ||
                                (run_end && (run_order_q || wr_order));
            timeout_flag <= (timeout_flag && !status_rd) || timeout_end;
        end
    end

    // Failure counter, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            failure_counter <= qa_watchdog_pkg::FAIL_CNT_RESET;
        end else if (fail_up) begin
            if (failure_counter != qa_watchdog_pkg::FAIL_CNT_MAX) begin
                failure_counter <= failure_counter + 4'h1;
            end
        end else if (fail_down) begin
            if (failure_counter != qa_watchdog_pkg::FAIL_CNT_MIN) begin
                failure_counter <= failure_counter - 4'h1;
            end
        end
    end

    // Fail flag, set on each increment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_fail_flag <= 1'b0;
        end else if (init_req) begin
            watchdog_fail_flag <= 1'b0;
        end else if (fail_up && failure_counter != qa_watchdog_pkg::FAIL_CNT_MAX) begin
            watchdog_fail_flag <= 1'b1;
        end
    end

endmodule // question_answer_watchdog

// [verification/qa_watchdog_monitor.sv]
// Port-level checks on the watchdog
module qa_watchdog_monitor #(
    parameter int STEP_CYC = qa_watchdog_pkg::STEP_CYCLES // Clocks per step
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic state_a, // Diag state
    input wire logic cfg_wr, // Setting write
    input wire logic [7:0] window_one_config, // First setting
    input wire logic init_req, // Init event
    input wire logic question_rd, // Question read
    input wire logic frame_fault, // Frame fault
    input wire logic answer_wr, // Answer write
    input wire logic status_rd, // Status read
    input wire logic [3:0] pending_question, // Question
    input wire logic [1:0] answer_countdown, // Countdown
    input wire logic question_event, // Read pulse
    input wire logic wrong_answer_flag, // Wrong flag
    input wire logic early_answer_flag, // Early flag
    input wire logic order_error_flag, // Order flag
    input wire logic timeout_flag, // Time-out flag
    input wire logic watchdog_fail_flag, // Fail flag
    input wire logic [3:0] failure_counter, // Fail count
    input wire logic second_window, // Second window
    input wire logic config_locked, // Locked
    input wire logic [7:0] first_window_length, // First length
    input wire logic [4:0] second_window_length // Second length
);
    logic any_flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Any status flag set
    assign any_flag = wrong_answer_flag | early_answer_flag | order_error_flag | timeout_flag;

    // Final byte taken, then restart and new question
    sequence s_final;
        answer_wr && second_window && answer_countdown == 2'h0 && !state_a && !cfg_wr && !init_req;
    endsequence
    sequence s_restart;
        !second_window && answer_countdown == 2'h3 ##1 $changed(pending_question);
    endsequence

    a_event_valid: assert property (question_rd && !frame_fault |=> question_event)
        else $error("no question event after clean read");
    a_event_fault: assert property (question_rd && frame_fault |=> !question_event)
        else $error("question event after faulty read");
    a_count_step: assert property (answer_wr && answer_countdown > 2'h1 && !second_window && !state_a
        && !init_req && !cfg_wr |=> answer_countdown == $past(answer_countdown) - 2'h1)
        else $error("countdown did not step down");
    a_final_restart: assert property (s_final |=> s_restart)
        else $error("no restart after final byte");
    a_status_clear: assert property (status_rd && !second_window && !init_req |=> !any_flag)
        else $error("status read did not clear flags");
    a_flag_end: assert property ($rose(any_flag) |-> $fell(second_window))
        else $error("flag set away from cycle end");
    a_fc_step: assert property ($changed(failure_counter) |-> failure_counter == $past(failure_counter) + 4'h1
        || failure_counter == $past(failure_counter) - 4'h1)
        else $error("failure counter jumped");
    a_fc_sat: assert property (!(($past(failure_counter) == 4'hF && failure_counter == 4'h0)
        || ($past(failure_counter) == 4'h0 && failure_counter == 4'hF)))
        else $error("failure counter wrapped");
    a_fail_mark: assert property (failure_counter == $past(failure_counter) + 4'h1 && !$past(init_req)
        |-> watchdog_fail_flag)
        else $error("fail flag missing on increment");
    a_lock_hold: assert property (config_locked && cfg_wr |=> $stable(first_window_length)
        && $stable(second_window_length))
        else $error("locked settings changed");
    a_cfg_load: assert property (cfg_wr && state_a && !config_locked
        |=> first_window_length == $past(window_one_config) && !second_window)
        else $error("setting write not taken");
    a_init_clear: assert property (init_req |=> !any_flag && !watchdog_fail_flag ##1 pending_question == 4'h1)
        else $error("init did not clear");
endmodule // qa_watchdog_monitor

bind question_answer_watchdog qa_watchdog_monitor #(.STEP_CYC(STEP_CYC)) i_qa_watchdog_monitor (
    .clk(clk), .rst_n(rst_n), .state_a(state_a), .cfg_wr(cfg_wr), .window_one_config(window_one_config),
    .init_req(init_req), .question_rd(question_rd), .frame_fault(frame_fault), .answer_wr(answer_wr),
    .status_rd(status_rd), .pending_question(pending_question), .answer_countdown(answer_countdown),
    .question_event(question_event), .wrong_answer_flag(wrong_answer_flag),
    .early_answer_flag(early_answer_flag), .order_error_flag(order_error_flag), .timeout_flag(timeout_flag),
    .watchdog_fail_flag(watchdog_fail_flag), .failure_counter(failure_counter),
    .second_window(second_window), .config_locked(config_locked),
    .first_window_length(first_window_length), .second_window_length(second_window_length));

// [verification/mcu_model.sv]
// Supervised controller writing answer bytes
module mcu_model (
    input wire logic clk, // Clock
    input wire logic send, // Issue one write
    input wire logic bad, // Corrupt it
    input wire logic [3:0] q, // Question
    input wire logic [1:0] cnt, // Countdown
    input wire logic [1:0] fb, // Feedback
    output logic answer_wr, // Write strobe
    output logic [7:0] answer_byte_field // Answer byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ans;

    // Answer byte from question, countdown, feedback
    assign ans = {q ^ {cnt, fb}, ~q ^ {fb, cnt}};

    initial begin
        answer_wr = 1'b0;
        answer_byte_field = 8'h00;
    end

    // One byte per request; idle bus inverts every cycle
    always @(posedge clk) begin
        answer_wr <= send;
        answer_byte_field <= send ? (ans ^ {7'h00, bad}) : ~answer_byte_field;
    end
endmodule // mcu_model

// [verification/question_answer_watchdog_tb.sv]
// Watchdog testbench
module question_answer_watchdog_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic state_a = 1'b0, mode = 1'b0, cfg_wr = 1'b0, lock = 1'b0, init_req = 1'b0;
    logic qrd = 1'b0, fault = 1'b0, srd = 1'b0, send = 1'b0, bad = 1'b0;
    logic [7:0] w1 = 8'h00;
    logic [4:0] w2 = 5'h00;
    logic [1:0] fb = 2'h0;
    logic awr, qev, werr, eerr, oerr, tout, wfail, sw, locked;
    logic [7:0] abyte, len1;
    logic [3:0] pq, fc, efc, q0, qn;
    logic [1:0] cnt;
    logic [4:0] len2;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    question_answer_watchdog #(.STEP_CYC(STEP)) i_question_answer_watchdog (
        .clk(clk), .rst_n(rst_n), .state_a(state_a), .answer_mode_select(mode), .cfg_wr(cfg_wr),
        .window_one_config(w1), .window_two_config(w2), .answer_feedback_config(fb),
        .config_write_lock_cmd(lock), .init_req(init_req), .question_rd(qrd), .frame_fault(fault),
        .answer_wr(awr), .answer_byte_field(abyte), .status_rd(srd), .pending_question(pq),
        .answer_countdown(cnt), .question_event(qev), .wrong_answer_flag(werr), .early_answer_flag(eerr),
        .order_error_flag(oerr), .timeout_flag(tout), .watchdog_fail_flag(wfail), .failure_counter(fc),
        .second_window(sw), .config_locked(locked), .first_window_length(len1), .second_window_length(len2));

    mcu_model i_mcu_model (.clk(clk), .send(send), .bad(bad), .q(pq), .cnt(cnt), .fb(fb),
        .answer_wr(awr), .answer_byte_field(abyte));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic mid();
        @(negedge clk);
    endtask

    // Wait for a window level, or count cycles at the present level
    task automatic lvl(input logic v);
        for (int k = 0; sw !== v && k < 3000; k++) mid();
    endtask

    task automatic span(output int k);
        logic lv;
        lv = sw;
        k = 0;
        while (sw === lv && k < 2000) begin
            mid();
            k++;
        end
    endtask

    task automatic answer(input logic b);
        tick(1);
        send <= 1'b1;
        bad <= b;
        tick(1);
        send <= 1'b0;
        tick(3);
    endtask

    task automatic status_read();
        tick(1);
        srd <= 1'b1;
        tick(1);
        srd <= 1'b0;
        mid();
    endtask

    // Full multi-answer run, first byte optionally wrong
    task automatic run_multi(input logic b);
        for (int i = 0; i < 3; i++) begin
            answer(b && i == 0);
            mid();
            chk(8'(cnt), 8'(2 - i));
        end
        lvl(1'b1);
        q0 = pq;
        qn = {q0[2:0], q0[3] ^ q0[2]};
        if (qn == 4'h0) qn = 4'h1;
        efc = b ? efc + 4'h1 : efc - 4'h1;
        answer(1'b0);
        mid();
        chk(8'(cnt), 8'h03);
        chk(8'(sw), 8'h00);
        chk(8'(werr), 8'(b));
        chk(8'(fc), 8'(efc));
        chk(8'(pq), 8'(qn));
        status_read();
        chk(8'(werr), 8'h00);
    endtask

    task automatic conclude();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(12);
        rst_n <= 1'b1;
        efc = 4'h5;
        mid();
        chk(8'(pq), 8'h01);
        chk(8'(cnt), 8'h03);
        chk(8'(fc), 8'(efc));
        chk(len1, 8'h0F);
        tick(1);
        qrd <= 1'b1;
        fault <= 1'b1;
        tick(1);
        fault <= 1'b0;
        mid();
        chk(8'(qev), 8'h00);
        tick(1);
        qrd <= 1'b0;
        mid();
        chk(8'(qev), 8'h01);
        mid();
        chk(8'(qev), 8'h00);
        tick(1);
        state_a <= 1'b1;
        cfg_wr <= 1'b1;
        w1 <= 8'h07;
        w2 <= 5'h02;
        fb <= 2'h2;
        tick(1);
        state_a <= 1'b0;
        cfg_wr <= 1'b0;
        efc = efc + 4'h1;
        tick(1);
        mid();
        chk(len1, 8'h07);
        chk(8'(len2), 8'h02);
        chk(8'(fc), 8'(efc));
        lvl(1'b1);
        span(n);
        chk(8'(n), 8'(3 * STEP));
        efc = efc + 4'h1;
        chk(8'(tout), 8'h01);
        chk(8'(wfail), 8'h01);
        chk(8'(fc), 8'(efc));
        span(n);
        chk(8'(n), 8'(8 * STEP));
        status_read();
        chk(8'(tout), 8'h00);
        lvl(1'b0);
        efc = efc + 4'h1;
        run_multi(1'b0);
        run_multi(1'b1);
        // Fourth byte still in first window: early and order error at time-out
        for (int i = 0; i < 4; i++) answer(1'b0);
        chk(8'(oerr), 8'h00);
        lvl(1'b1);
        lvl(1'b0);
        chk(8'(oerr), 8'h01);
        chk(8'(eerr), 8'h01);
        chk(8'(tout), 8'h01);
        status_read();
        chk(8'(oerr), 8'h00);
        tick(1);
        cfg_wr <= 1'b1;
        w1 <= 8'h01;
        tick(1);
        cfg_wr <= 1'b0;
        lock <= 1'b1;
        tick(1);
        lock <= 1'b0;
        state_a <= 1'b1;
        cfg_wr <= 1'b1;
        tick(1);
        state_a <= 1'b0;
        cfg_wr <= 1'b0;
        mid();
        chk(len1, 8'h07);
        chk(8'(locked), 8'h01);
        tick(1);
        state_a <= 1'b1;
        mode <= 1'b1;
        tick(1);
        state_a <= 1'b0;
        mid();
        chk(8'(cnt), 8'h01);
        answer(1'b0);
        mid();
        chk(8'(eerr), 8'h00);
        chk(8'(cnt), 8'h01);
        lvl(1'b1);
        lvl(1'b0);
        chk(8'(eerr), 8'h01);
        lvl(1'b1);
        answer(1'b0);
        mid();
        chk(8'(sw), 8'h00);
        chk(8'(cnt), 8'h01);
        tick(1);
        init_req <= 1'b1;
        tick(1);
        init_req <= 1'b0;
        tick(1);
        mid();
        chk(8'(eerr), 8'h00);
        chk(8'(wfail), 8'h00);
        chk(8'(pq), 8'h01);
        chk(8'(cnt), 8'h01);
        conclude();
    end
endmodule // question_answer_watchdog_tb
